/* src/lhc_pkg.sv */
// shared constants for the caption decoder host-control block
package lhc_pkg;
  // command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_RESET_ARM = 8'hFB;
  localparam logic [7:0] CMD_REQ_CLEAR = 8'hF0;
  localparam logic [7:0] CMD_FILTER = 8'hC5;
  localparam logic [7:0] CMD_MASK = 8'hC7;
  // two-byte commands: upper nibble C, bit 3 low (C0..C7)
  localparam logic [3:0] CMD_PAIR_HI = 4'hC;
  localparam int CMD_PAIR_SEL_BIT = 3;
  // reset values
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] REQ_RESET = 8'h00;
  // event bit positions in mask and request registers
  localparam int EV_EOF = 0;
  localparam int EV_DLE = 1;
  localparam int EV_LOCK = 3;
  localparam int EV_CT = 4;
  localparam int EV_XDS = 5;
  // status register bit positions
  localparam int ST_LOCK = 0;
  localparam int ST_FIELD = 1;
  localparam int ST_IRQ = 3;
  localparam int ST_READY = 7;
  // i2c slave addresses, 8-bit form with r/w in bit 0
  localparam logic [7:0] I2C_ADDR_MAIN = 8'h28;
  localparam logic [7:0] I2C_ADDR_ALT = 8'h2A;
  // serial framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // command processing time during which ready reads low
  localparam int PROC_TIME_NS = 40;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int PROC_CYCLES = (PROC_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // command interpreter states
  typedef enum logic [2:0] {
    LHC_IDLE = 3'b001,
    LHC_VALUE = 3'b010,
    LHC_BUSY = 3'b100
  } lhc_cmd_state_e;
endpackage

/* src/lhc_host_control.sv */
// serial command port, packet filter and interrupt logic of the caption decoder
`timescale 1ns/10ps
module lhc_host_control
  import lhc_pkg::*;
#(
  parameter int PROC_LEN = PROC_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic serial_clk,
  input wire logic spi_mode_pin,
  input wire logic addr_sel_pin,
  input wire logic spi_select_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  input wire logic vlock_internal,
  input wire logic video_field_flag,
  input wire logic video_lock,
  input wire logic field_end,
  input wire logic end_of_field_event,
  input wire logic data_line_event,
  input wire logic caption_text_change_event,
  input wire logic lock_change_event,
  input wire logic extended_data_change_event,
  input wire logic xds_packet_valid,
  input wire logic [7:0] xds_packet_match,
  output logic xds_packet_accept,
  output logic xds_recovery_en,
  output logic [7:0] extended_data_packet_filter,
  output logic [7:0] interrupt_enable_mask,
  output logic [7:0] interrupt_request,
  output logic [7:0] serial_port_status,
  output logic interrupt_request_out,
  output logic vsync_pin_oe
);

  // ---------------- mclk side: strap and i2c line synchronisers
  logic mode_s1, mode_s2;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic i2c_clear;

  // serial clock doubles as scl; sampled here only for start and stop detection
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else if (ce) begin
      mode_s1 <= spi_mode_pin;
      mode_s2 <= mode_s1;
      scl_s1 <= serial_clk;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= i2c_sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // start or stop holds the link framing cleared until scl falls again
  always_ff @(posedge mclk) begin
    if (reset) begin
      i2c_clear <= 1'b1;
    end else if (ce) begin
      if (scl_s2 && scl_s3 && (sda_s2 != sda_s3)) begin
        i2c_clear <= 1'b1;
      end else if (!scl_s2) begin
        i2c_clear <= 1'b0;
      end
    end
  end

  // clear of the link framing: chip select in spi, bus conditions in i2c
  logic link_clear;
  assign link_clear = mode_s2 ? spi_select_n : (i2c_clear | reset);

  // ---------------- link side, clocked by the master's serial clock
  logic lmode_s1, lmode_s2;
  logic laddr_s1, laddr_s2;
  logic [7:0] stat_s1, stat_s2;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic past_addr;
  logic addressed;
  logic read_dir;
  logic [7:0] tx_shift;
  logic din;
  logic [7:0] rx_next;
  logic [7:0] addr_cmp;
  logic byte_end;
  assign din = lmode_s2 ? spi_mosi : i2c_sda_in;
  assign rx_next = {rx_shift[6:0], din};
  assign addr_cmp = laddr_s2 ? I2C_ADDR_ALT : I2C_ADDR_MAIN;
  assign byte_end = lmode_s2 ? (bit_cnt == BIT_LAST) : (bit_cnt == BIT_ACK);
  // status bits are independent levels, so each passes two flops
  always_ff @(posedge serial_clk) begin
    lmode_s1 <= spi_mode_pin;
    lmode_s2 <= lmode_s1;
    laddr_s1 <= addr_sel_pin;
    laddr_s2 <= laddr_s1;
    stat_s1 <= serial_port_status;
    stat_s2 <= stat_s1;
  end
  // bit framing; i2c adds a ninth acknowledge clock per byte
  always_ff @(posedge serial_clk or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt <= 4'h0;
      past_addr <= 1'b0;
      addressed <= 1'b0;
      read_dir <= 1'b0;
    end else begin
      if (byte_end) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (!lmode_s2 && !past_addr && bit_cnt == BIT_LAST) begin
        addressed <= (rx_next[7:1] == addr_cmp[7:1]);
        read_dir <= rx_next[0];
      end
      if (!lmode_s2 && bit_cnt == BIT_ACK) begin
        past_addr <= 1'b1;
      end
    end
  end
  // data shifting and byte hand-off; the byte stays stable for eight clocks
  always_ff @(posedge serial_clk) begin
    if (bit_cnt <= BIT_LAST) begin
      rx_shift <= rx_next;
    end
    if (bit_cnt == BIT_LAST && (lmode_s2 || (past_addr && addressed && !read_dir))) begin
      rx_byte <= rx_next;
    end
    if (byte_end) begin
      tx_shift <= stat_s2;
    end
  end
  // toggle and its mclk-side synchroniser leave reset at one level, so no false byte follows reset
  always_ff @(posedge serial_clk or posedge reset) begin
    if (reset) begin
      rx_toggle <= 1'b0;
    end else if (bit_cnt == BIT_LAST && (lmode_s2 || (past_addr && addressed && !read_dir))) begin
      rx_toggle <= ~rx_toggle;
    end
  end
  // miso keeps its bit between frames, so the status msb stands before the first rising edge
  always_ff @(negedge serial_clk) begin
    spi_miso <= tx_shift[3'h7 - bit_cnt[2:0]];
  end
  // sda drive changes on the falling edge so the master samples it stable
  always_ff @(negedge serial_clk or posedge link_clear) begin
    if (link_clear) begin
      i2c_sda_out <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end else begin
      i2c_sda_out <= 1'b0;
      if (lmode_s2) begin
        i2c_sda_oe <= 1'b0;
      end else if (bit_cnt == BIT_ACK) begin
        i2c_sda_oe <= past_addr ? (addressed && !read_dir) : addressed;
      end else if (past_addr && addressed && read_dir) begin
        i2c_sda_oe <= ~tx_shift[3'h7 - bit_cnt[2:0]]; // open drain: drive only zeros
      end else begin
        i2c_sda_oe <= 1'b0;
      end
    end
  end

  // ---------------- mclk side: byte arrival
  logic tog_s1, tog_s2, tog_s3;
  logic byte_strobe;
  // toggle synchroniser; the third flop only marks the edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else if (ce) begin
      tog_s1 <= rx_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  assign byte_strobe = tog_s2 ^ tog_s3;
  // ---------------- command interpreter
  lhc_cmd_state_e cmd_state;
  logic [7:0] reg_sel;
  logic [7:0] cmd_byte;
  logic reset_armed;
  logic soft_reset;
  logic req_clear;
  logic port_ready;
  logic [$clog2(PROC_LEN + 1)-1:0] busy_cnt;

  // byte is only read after the toggle edge, long after it settled
  assign cmd_byte = rx_byte;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_state <= LHC_IDLE;
      reg_sel <= CMD_NOP;
      reset_armed <= 1'b0;
      soft_reset <= 1'b0;
      req_clear <= 1'b0;
      port_ready <= 1'b1;
      busy_cnt <= '0;
    end else if (ce) begin
      soft_reset <= 1'b0;
      req_clear <= 1'b0;
      unique case (cmd_state)
        LHC_IDLE: begin
          if (byte_strobe) begin
            port_ready <= 1'b0;
            if (cmd_byte[7:4] == CMD_PAIR_HI && !cmd_byte[CMD_PAIR_SEL_BIT]) begin
              reg_sel <= cmd_byte;
              cmd_state <= LHC_VALUE;
            end else begin
              // single-byte commands; nop right after reset-arm is a soft reset, otherwise nop leaves every register alone
              reset_armed <= (cmd_byte == CMD_RESET_ARM);
              soft_reset <= reset_armed && (cmd_byte == CMD_NOP);
              req_clear <= (cmd_byte == CMD_REQ_CLEAR);
              cmd_state <= LHC_BUSY;
            end
            busy_cnt <= '0;
          end
        end
        LHC_VALUE: begin
          // ready rises between the two bytes of a pair
          if (busy_cnt != PROC_LEN[$bits(busy_cnt)-1:0]) begin
            busy_cnt <= busy_cnt + 1'b1;
          end else begin
            port_ready <= 1'b1;
          end
          if (byte_strobe) begin
            port_ready <= 1'b0;
            reset_armed <= 1'b0;
            busy_cnt <= '0;
            cmd_state <= LHC_BUSY;
          end
        end
        LHC_BUSY: begin
          if (busy_cnt == PROC_LEN[$bits(busy_cnt)-1:0]) begin
            port_ready <= 1'b1;
            busy_cnt <= '0;
            cmd_state <= LHC_IDLE;
          end else begin
            busy_cnt <= busy_cnt + 1'b1;
          end
        end
      endcase
    end
  end
  logic value_write;
  assign value_write = (cmd_state == LHC_VALUE) && byte_strobe;
  // filter and mask registers; other pair selects are taken and dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      extended_data_packet_filter <= FILTER_RESET;
      interrupt_enable_mask <= MASK_RESET;
    end else if (ce) begin
      if (soft_reset) begin
        extended_data_packet_filter <= FILTER_RESET;
        interrupt_enable_mask <= MASK_RESET;
      end else if (value_write && reg_sel == CMD_FILTER) begin
        extended_data_packet_filter <= cmd_byte;
      end else if (value_write && reg_sel == CMD_MASK) begin
        interrupt_enable_mask <= cmd_byte;
      end
    end
  end

  // ---------------- extended-data gate
  // a packet passes when it matches any selected filter bit, so 1F passes the bit 0 to 4
  // classes and compound values narrow the match to their own bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      xds_recovery_en <= 1'b0;
      xds_packet_accept <= 1'b0;
    end else if (ce) begin
      xds_recovery_en <= (extended_data_packet_filter != FILTER_RESET);
      xds_packet_accept <= xds_packet_valid && (|(xds_packet_match & extended_data_packet_filter));
    end
  end

  // ---------------- interrupt request register
  logic [7:0] ev_vec;
  logic [7:0] clr_vec;
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[EV_EOF] = end_of_field_event;
    ev_vec[EV_DLE] = data_line_event;
    ev_vec[EV_LOCK] = lock_change_event;
    ev_vec[EV_CT] = caption_text_change_event;
    ev_vec[EV_XDS] = extended_data_change_event;
    clr_vec = 8'h00;
    if (field_end) begin
      clr_vec[EV_EOF] = 1'b1;
      clr_vec[EV_DLE] = 1'b1;
    end
    if (req_clear || soft_reset) begin
      clr_vec = 8'hFF;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      interrupt_request <= REQ_RESET;
    end else if (ce) begin
      interrupt_request <= (interrupt_request & ~clr_vec) | ev_vec;
    end
  end

  // interrupt pin and status
  logic irq_pending;
  assign irq_pending = |(interrupt_request & interrupt_enable_mask);

  always_ff @(posedge mclk) begin
    if (reset) begin
      interrupt_request_out <= 1'b0;
      vsync_pin_oe <= 1'b0;
      serial_port_status <= 8'h00;
    end else if (ce) begin
      interrupt_request_out <= irq_pending;
      vsync_pin_oe <= vlock_internal;
      serial_port_status <= 8'h00;
      serial_port_status[ST_READY] <= port_ready;
      serial_port_status[ST_FIELD] <= video_field_flag;
      serial_port_status[ST_LOCK] <= video_lock;
      serial_port_status[ST_IRQ] <= irq_pending;
    end
  end

endmodule // lhc_host_control

/* dv/lhc_host_sva.sv */
// checker for the host-control ports
`timescale 1ns/10ps
module lhc_host_sva
  import lhc_pkg::*;
#(
  parameter int PROC_LEN = PROC_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic xds_packet_valid,
  input wire logic [7:0] xds_packet_match,
  input wire logic xds_packet_accept,
  input wire logic xds_recovery_en,
  input wire logic [7:0] extended_data_packet_filter,
  input wire logic [7:0] interrupt_enable_mask,
  input wire logic [7:0] interrupt_request,
  input wire logic [7:0] serial_port_status,
  input wire logic interrupt_request_out,
  input wire logic vlock_internal,
  input wire logic vsync_pin_oe,
  input wire logic field_end,
  input wire logic data_line_event,
  input wire logic end_of_field_event
);
  // ready returns within processing time plus sync margin
  localparam int RDY_MAX = PROC_LEN + 8;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_accept;
    ce |=> xds_packet_accept == ($past(xds_packet_valid)
      && |($past(xds_packet_match) & $past(extended_data_packet_filter)));
  endproperty
  a_accept: assert property (p_accept) else $error("packet gate wrong");
  property p_recov;
    ce |=> xds_recovery_en == ($past(extended_data_packet_filter) != 8'h00);
  endproperty
  a_recov: assert property (p_recov) else $error("recovery enable wrong");
  property p_irq;
    ce |=> interrupt_request_out == |($past(interrupt_request) & $past(interrupt_enable_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt out wrong");
  property p_stat_irq;
    interrupt_request_out |-> ##[0:2] serial_port_status[ST_IRQ];
  endproperty
  a_stat_irq: assert property (p_stat_irq) else $error("status irq bit missing");
  property p_oe;
    ce |=> vsync_pin_oe == $past(vlock_internal);
  endproperty
  a_oe: assert property (p_oe) else $error("vsync pin direction wrong");
  property p_req_set;
    ce && data_line_event |=> interrupt_request[EV_DLE];
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not recorded");
  property p_eof_clr;
    ce && field_end && !data_line_event && !end_of_field_event
      |=> !interrupt_request[EV_DLE] && !interrupt_request[EV_EOF];
  endproperty
  a_eof_clr: assert property (p_eof_clr) else $error("field requests not cleared");
  property p_ready;
    $fell(serial_port_status[ST_READY]) |-> ##[1:RDY_MAX] serial_port_status[ST_READY];
  endproperty
  a_ready: assert property (p_ready) else $error("ready stuck low");
endmodule // lhc_host_sva
bind lhc_host_control lhc_host_sva #(.PROC_LEN(PROC_LEN)) u_sva (.mclk, .reset, .ce, .xds_packet_valid,
  .xds_packet_match, .xds_packet_accept, .xds_recovery_en, .extended_data_packet_filter, .interrupt_enable_mask,
  .interrupt_request, .serial_port_status, .interrupt_request_out, .vlock_internal, .vsync_pin_oe, .field_end,
  .data_line_event, .end_of_field_event);

/* dv/lhc_spi_host.sv */
// spi host model: one byte per frame, collects the status byte
`timescale 1ns/10ps
module lhc_spi_host (
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  input wire logic miso,
  input wire logic ready
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b1;
  end
  // clock runs only inside a frame, 160 ns period, odd offset to mclk
  task automatic send(input logic [7:0] b, output logic [7:0] st);
    #37;
    sel_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #80;
      sclk = 1'b1;
      st[i] = miso;
      #80;
      sclk = 1'b0;
    end
    #40;
    sel_n = 1'b1;
    mosi = ~mosi; // released line must not keep a stale bit
    #120;
    for (int n = 0; n < 200 && ready !== 1'b1; n++) #10;
  endtask
endmodule // lhc_spi_host

/* dv/tb.sv */
// self-checking bench for the host-control block
`timescale 1ns/10ps
module tb;
  import lhc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic vlock_internal = 1'b0;
  logic video_field_flag = 1'b0;
  logic video_lock = 1'b0;
  logic field_end = 1'b0;
  logic [5:0] ev = 6'h00;
  logic xds_packet_valid = 1'b0;
  logic [7:0] xds_packet_match = 8'h00;
  logic sclk, sel_n, mosi, miso, acc, rec_en, irq, oe;
  logic [7:0] filt, mask, req, stat, rx;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  lhc_host_control #(.PROC_LEN(4)) DUT (.mclk, .reset, .ce(1'b1), .serial_clk(sclk), .spi_mode_pin(1'b1),
    .addr_sel_pin(1'b0), .spi_select_n(sel_n), .spi_mosi(mosi), .spi_miso(miso), .i2c_sda_in(1'b1),
    .i2c_sda_out(), .i2c_sda_oe(), .vlock_internal, .video_field_flag, .video_lock, .field_end,
    .end_of_field_event(ev[0]), .data_line_event(ev[1]), .caption_text_change_event(ev[4]),
    .lock_change_event(ev[3]), .extended_data_change_event(ev[5]), .xds_packet_valid, .xds_packet_match,
    .xds_packet_accept(acc), .xds_recovery_en(rec_en), .extended_data_packet_filter(filt),
    .interrupt_enable_mask(mask), .interrupt_request(req), .serial_port_status(stat),
    .interrupt_request_out(irq), .vsync_pin_oe(oe));
  lhc_spi_host host (.sclk, .sel_n, .mosi, .miso, .ready(stat[ST_READY]));
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.send(b, rx);
    step(2);
  endtask
  // accept is a one-cycle pulse right after the valid cycle
  task automatic pkt(input logic [7:0] m, input logic exp);
    xds_packet_valid = 1'b1;
    xds_packet_match = m;
    step(1);
    xds_packet_valid = 1'b0;
    chk("accept", {7'h00, exp}, {7'h00, acc});
  endtask
  task automatic ev_pulse(input int b);
    ev[b] = 1'b1;
    step(1);
    ev[b] = 1'b0;
    step(3);
  endtask
  task automatic t_reset();
    chk("filter", FILTER_RESET, filt);
    chk("mask", MASK_RESET, mask);
    chk("request", REQ_RESET, req);
    chk("status", 8'h80, stat);
    pkt(8'hFF, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_status();
    video_field_flag = 1'b1;
    video_lock = 1'b1;
    cmd(CMD_NOP);
    cmd(CMD_NOP);
    chk("nop status", 8'h83, rx);
    chk("filter kept", FILTER_RESET, filt);
    $display("test status done");
  endtask
  task automatic t_filter();
    logic [7:0] tbl [9] = '{8'h1F, 8'h00, 8'h01, 8'h41, 8'h02, 8'h04, 8'h08, 8'h28, 8'h9E};
    foreach (tbl[i]) begin
      cmd(CMD_FILTER);
      cmd(tbl[i]);
      chk("filter", tbl[i], filt);
      chk("recovery", {7'h00, tbl[i] != 8'h00}, {7'h00, rec_en});
      pkt(8'h01, tbl[i][0]);
      pkt(8'h20, tbl[i][5]);
    end
    $display("test filter done");
  endtask
  task automatic t_irq();
    logic [7:0] mk [4] = '{8'h02, 8'h08, 8'h20, 8'h12};
    int bt [4] = '{EV_DLE, EV_LOCK, EV_XDS, EV_CT};
    vlock_internal = 1'b1;
    cmd(CMD_MASK);
    cmd(8'h00);
    ev_pulse(EV_DLE);
    chk("req dle", 8'h02, req);
    chk("irq masked", 8'h00, {7'h00, irq});
    chk("pin oe", 8'h01, {7'h00, oe});
    field_end = 1'b1;
    step(1);
    field_end = 1'b0;
    step(1);
    chk("req field end", 8'h00, req);
    foreach (mk[i]) begin
      cmd(CMD_MASK);
      cmd(mk[i]);
      chk("mask", mk[i], mask);
      ev_pulse(bt[i]);
      chk("irq", 8'h01, {7'h00, irq});
      chk("status irq", 8'h01, {7'h00, stat[ST_IRQ]});
      cmd(CMD_REQ_CLEAR);
      chk("req clear", 8'h00, req);
    end
    $display("test interrupt done");
  endtask
  task automatic t_soft();
    cmd(CMD_FILTER);
    cmd(8'h1F);
    cmd(CMD_RESET_ARM);
    cmd(CMD_NOP);
    chk("filter soft", FILTER_RESET, filt);
    chk("mask soft", MASK_RESET, mask);
    $display("test soft reset done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    step(20);
    reset = 1'b0;
    step(12);
    t_reset();
    // second reset: one idle frame lets the link-side strap synchronisers settle while framing is held clear
    reset = 1'b1;
    host.send(CMD_NOP, rx);
    step(1);
    reset = 1'b0;
    step(12);
    t_reset();
    t_status();
    t_filter();
    t_irq();
    t_soft();
    wrap_up();
  end
endmodule // tb
